// [pcpg_top.sv]
/*
  pcpg_top: pulse settings conflict checker and multi-level
  pseudo-random pattern sequencer, classic wishbone register slave.
  assumes: one clock, trigger pin from another domain, sample
  consumer takes sample_o on each sample_stb_o pulse.
*/
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module pcpg_top (
  input  wire  logic                clk_i,
  input  wire  logic                srst_i,
  input  wire  logic                ce_i,
  input  wire  logic                wb_cyc_i,
  input  wire  logic                wb_stb_i,
  input  wire  logic                wb_we_i,
  input  wire  logic [31:0]         wb_adr_i,
  input  wire  logic [3:0]          wb_sel_i,
  input  wire  logic [31:0]         wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  input  wire  logic                trig_i,
  output logic signed [15:0]        sample_o,
  output logic                      sample_stb_o,
  output logic                      pattern_active_o,
  output logic                      err_sticky_o,
  output pcpg_pkg::pcpg_err_t       err_code_o
);
  import pcpg_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE  = 4'b0010,
    ST_PLAY = 4'b0100,
    ST_DONE = 4'b1000
  } pcpg_state_t;

  // register file
  logic [31:0] regs [NREG];
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        err_reg;
  pcpg_err_t   code_reg;

  wire logic [AW-1:0] widx   = wb_adr_i[AW+1:2];
  wire logic          hit    = (wb_adr_i[31:AW+2] == '0) && (widx < AW'(NREG));
  wire logic          req    = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic          wr     = req && wb_we_i && hit;
  wire logic [31:0]   bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic          clr_wr = wr && (widx == R_CTRL) && wb_sel_i[0] && wb_dat_i[C_CLRERR];

  function automatic logic [31:0] rst_val(input int unsigned i);
    logic [31:0] v;
    v = REG_RST[i];
    case (AW'(i))
      R_LEVELS: v = RST_LEVELS;
      R_AMPLIM: v = RST_AMPLIM;
      R_WINDOW: v = RST_WINDOW;
      R_PATCFG: v = RST_PATCFG;
      R_BAUD:   v = RST_BAUD;
      R_LENGTH: v = RST_LENGTH;
      R_PREAMB: v = RST_PREAMB;
      R_LOOPS:  v = RST_LOOPS;
      default:  v = REG_RST[i];
    endcase
    return v;
  endfunction

  function automatic logic [TW-1:0] time_of(input logic [31:0] hi, input logic [31:0] lo);
    return TW'({hi[7:0], lo});
  endfunction

  // status word shows block state one cycle behind st_reg, with the registered error code and sticky flag
  logic [3:0] state_reg;
  wire logic [31:0] status_w = {24'h0, state_reg, code_reg, err_reg};
  wire logic [31:0] rd_w = !hit ? 32'h0 :
                           (widx == R_STATUS) ? status_w :
                           (widx == R_CTRL) ? (regs[widx] & ~(32'h1 << C_CLRERR)) :
                           regs[widx];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= rst_val(i);
      end
    end else if (ce_i && wr && widx != R_STATUS) begin
      regs[widx] <= (regs[widx] & ~bmask) | (wb_dat_i & bmask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else if (ce_i) begin
      ack_reg  <= req;
      rdat_reg <= rd_w;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // settings conflict checks
  wire logic [31:0] ctrl   = regs[R_CTRL];
  wire logic signed [16:0] top_mv = 17'(signed'(regs[R_LEVELS][15:0]));
  wire logic signed [16:0] bot_mv = 17'(signed'(regs[R_LEVELS][31:16]));
  wire logic signed [16:0] amp_min = 17'(signed'(regs[R_AMPLIM][15:0]));
  wire logic signed [16:0] amp_max = 17'(signed'(regs[R_AMPLIM][31:16]));
  wire logic signed [16:0] win_max = 17'(signed'(regs[R_WINDOW][15:0]));
  wire logic signed [16:0] win_min = 17'(signed'(regs[R_WINDOW][31:16]));
  wire logic signed [16:0] lv_diff = top_mv - bot_mv;
  wire logic signed [16:0] lv_sum  = top_mv + bot_mv;

  wire logic [TW-1:0] per_u  = time_of(regs[R_PER_LO + AW'(1)], regs[R_PER_LO]);
  wire logic [TW-1:0] span_u = time_of(regs[R_SPAN_LO + AW'(1)], regs[R_SPAN_LO]);
  wire logic [TW-1:0] ofs_u  = time_of(regs[R_OFS_LO + AW'(1)], regs[R_OFS_LO]);
  wire logic [TW-1:0] rise_u = time_of(regs[R_RISE_LO + AW'(1)], regs[R_RISE_LO]);
  wire logic [TW-1:0] fall_u = time_of(regs[R_FALL_LO + AW'(1)], regs[R_FALL_LO]);
  wire logic [TW-1:0] step_u = time_of(regs[R_STEP_LO + AW'(1)], regs[R_STEP_LO]);
  wire logic [TW-1:0] sf_u   = span_u + fall_u;
  wire logic [TW-1:0] pts_u  = TW'(step_u * MEM_MAX_U);

  // reversed levels give a negative span, below the minimum
  wire logic e_ampl = (lv_diff < amp_min) || (lv_sum > amp_max) ||
                      (top_mv > win_max) || (bot_mv < win_min);
  wire logic e_tim  = (per_u > SPAN_MAX_U) || (per_u < PER_MIN_U) ||
                      (rise_u > span_u);
  wire logic e_edge = (rise_u < EDGE_MIN_U) || (fall_u < EDGE_MIN_U) ||
                      (rise_u > EDGE_MAX_U) || (fall_u > EDGE_MAX_U) ||
                      (sf_u > SPAN_MAX_U);
  wire logic e_ofs_rng = (ofs_u < OFS_MIN_U) || (ofs_u > OFS_MAX_U);
  wire logic e_single  = !ctrl[C_DOUBLE] && (ofs_u + sf_u > SPAN_MAX_U);
  wire logic e_double  = ctrl[C_DOUBLE] &&
                         (ofs_u + (sf_u << 1) > SPAN_MAX_U);
  wire logic e_delay = !ctrl[C_PATTERN] && (e_ofs_rng || e_single || e_double);
  wire logic e_gen   = (step_u < RES_MIN_U) || (step_u < SCLK_MIN_U) ||
                       (per_u > pts_u);

  // priority pick keeps only the first conflict
  wire pcpg_err_t code_w = e_ampl  ? ERR_AMPL :
                           e_tim   ? ERR_TIMING :
                           e_edge  ? ERR_EDGE :
                           e_delay ? ERR_DELAY :
                           e_gen   ? ERR_GEN : ERR_NONE;

  // set wins over clear; pattern output never stops for it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      err_reg  <= 1'b0;
      code_reg <= ERR_NONE;
    end else if (ce_i) begin
      code_reg <= code_w;
      err_reg  <= (code_w != ERR_NONE) || (err_reg && !clr_wr);
    end
  end
  assign err_sticky_o = err_reg;
  assign err_code_o   = code_reg;

  // pattern generator
  wire logic [2:0]  ptype  = regs[R_PATCFG][P_TYPE_LSB +: 3];
  wire logic [2:0]  nlev_r = regs[R_PATCFG][P_NLEV_LSB +: 3];
  wire logic [2:0]  nlev   = (nlev_r < 3'h2 || nlev_r > 3'h5) ? 3'h2 : nlev_r;
  wire logic [1:0]  kbits  = (nlev == 3'h2) ? 2'h1 : (nlev == 3'h5) ? 2'h3 : 2'h2;
  wire logic [30:0] taps   = regs[R_TAPS][30:0];
  wire logic [31:0] baud   = (regs[R_BAUD] > CLK_HZ) ? CLK_HZ : regs[R_BAUD];
  wire logic [31:0] len_b  = regs[R_LENGTH];
  wire logic [31:0] pre_b  = regs[R_PREAMB];
  wire logic [31:0] loops  = regs[R_LOOPS];

  function automatic logic [30:0] lfsr_step(input logic [30:0] s,
                                            input logic [2:0]  t,
                                            input logic [30:0] m);
    logic fb;
    fb = 1'b0;
    case (t)
      3'h0:    fb = s[6] ^ s[5];
      3'h1:    fb = s[8] ^ s[4];
      3'h2:    fb = s[10] ^ s[8];
      3'h3:    fb = s[14] ^ s[13];
      3'h4:    fb = s[22] ^ s[17];
      3'h5:    fb = s[30] ^ s[27];
      default: fb = ^(s & m);
    endcase
    return {s[29:0], fb};
  endfunction

  function automatic logic [30:0] lfsr_adv(input logic [30:0] s,
                                           input logic [1:0]  k,
                                           input logic [2:0]  t,
                                           input logic [30:0] m);
    logic [30:0] v;
    v = s;
    for (int i = 0; i < 3; i++) begin
      if (i < int'(k)) begin
        v = lfsr_step(v, t, m);
      end
    end
    return v;
  endfunction

  function automatic logic signed [15:0] level_of(input logic [2:0] sym,
                                                  input logic [2:0] n);
    logic signed [23:0] prod;
    logic signed [23:0] q;
    prod = 24'(lv_diff) * 24'(signed'({1'b0, sym}));
    q    = prod / 24'(signed'({1'b0, n - 3'h1}));
    return 16'(24'(bot_mv) + q);
  endfunction

  // trigger pin synchroniser
  logic trig_s1_reg;
  logic trig_s2_reg;
  logic trig_s3_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
    end else if (ce_i) begin
      trig_s1_reg <= trig_i;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end
  wire logic trig_rise = trig_s2_reg && !trig_s3_reg;

  // bit timing by rate accumulator, one symbol per tick
  logic [31:0] acc_reg;
  wire logic [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, baud};
  wire logic        tick    = acc_sum >= {1'b0, CLK_HZ};
  wire logic [31:0] acc_next = tick ? 32'(acc_sum - {1'b0, CLK_HZ}) : acc_sum[31:0];

  pcpg_state_t st_reg;
  pcpg_state_t st_next;
  logic [30:0] lfsr_reg;
  logic [30:0] start_reg;
  logic [31:0] cnt_reg;
  logic [31:0] loop_reg;
  logic        pend_reg;

  wire logic        run     = ctrl[C_RUN];
  wire logic [30:0] lfsr_nx = lfsr_adv(lfsr_reg, kbits, ptype, taps);
  wire logic [2:0]  sym_raw = (kbits == 2'h1) ? {2'h0, lfsr_nx[0]} :
                              (kbits == 2'h2) ? {1'b0, lfsr_nx[1:0]} : lfsr_nx[2:0];
  wire logic [2:0]  sym     = (sym_raw > nlev - 3'h1) ? nlev - 3'h1 : sym_raw;
  wire logic [31:0] cnt_nx  = cnt_reg + 32'(kbits);
  wire logic        pre_end = cnt_nx >= pre_b;
  wire logic        pat_end = cnt_nx >= len_b;
  wire logic        last    = ctrl[C_TRIG] && (loop_reg + 32'h1 >= loops);
  wire logic        emit    = tick && (st_reg == ST_PRE || st_reg == ST_PLAY);

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_IDLE: st_next = run ? ST_PRE : ST_IDLE;
      ST_PRE:  st_next = (tick && pre_end && (pend_reg || trig_rise)) ? ST_PLAY
                                                                       : ST_PRE;
      ST_PLAY: st_next = (tick && pat_end && last) ? ST_DONE : ST_PLAY;
      ST_DONE: st_next = ST_DONE;
      default: st_next = ST_IDLE;
    endcase
    if (!run) begin
      st_next = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= ST_IDLE;
      acc_reg <= 32'h0;
    end else if (ce_i) begin
      st_reg <= st_next;
      acc_reg <= (st_reg == ST_IDLE) ? 32'h0 : acc_next;
    end
  end

  // trigger held until the preamble pass ends; set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend_reg <= 1'b0;
    end else if (ce_i) begin
      pend_reg <= (st_reg == ST_PRE) && (trig_rise || (pend_reg && st_next == ST_PRE));
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lfsr_reg  <= LFSR_SEED;
      start_reg <= LFSR_SEED;
      cnt_reg   <= 32'h0;
      loop_reg  <= 32'h0;
    end else if (ce_i) begin
      if (st_reg == ST_IDLE) begin
        lfsr_reg <= LFSR_SEED;
        cnt_reg  <= 32'h0;
        loop_reg <= 32'h0;
      end else if (emit && st_reg == ST_PRE) begin
        cnt_reg  <= pre_end ? 32'h0 : cnt_nx;
        if (pre_end && st_next == ST_PRE) begin
          lfsr_reg <= LFSR_SEED;
        end else begin
          lfsr_reg <= lfsr_nx;
        end
        if (pre_end) begin
          start_reg <= lfsr_nx;
        end
      end else if (emit) begin
        cnt_reg  <= pat_end ? 32'h0 : cnt_nx;
        lfsr_reg <= pat_end ? start_reg : lfsr_nx;
        if (pat_end) begin
          loop_reg <= loop_reg + 32'h1;
        end
      end
    end
  end

  // nrz hold: sample changes on symbol ticks, and rests at the bottom level while idle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sample_o     <= 16'sh0;
      sample_stb_o <= 1'b0;
      state_reg    <= 4'h0;
    end else if (ce_i) begin
      sample_stb_o <= emit;
      state_reg    <= st_reg;
      if (emit) begin
        sample_o <= level_of(sym, nlev);
      end else if (st_reg == ST_IDLE) begin
        sample_o <= 16'(bot_mv);
      end
    end
  end
  assign pattern_active_o = (st_reg == ST_PLAY);

endmodule
`default_nettype wire

// [pcpg_pkg.sv]
/*
  pcpg_pkg: register map, field positions, reset values and limits
  of the pulse checker and pattern generator.
  assumes: 50 MHz clock, times counted in 100 ps units, levels in mV.
*/
`default_nettype none
package pcpg_pkg;
  localparam int unsigned NREG = 23;
  localparam int unsigned AW   = 5;
  // register word indices (byte address = 4 * index)
  localparam logic [AW-1:0] R_CTRL    = 5'h00;
  localparam logic [AW-1:0] R_STATUS  = 5'h01;
  localparam logic [AW-1:0] R_LEVELS  = 5'h02;
  localparam logic [AW-1:0] R_AMPLIM  = 5'h03;
  localparam logic [AW-1:0] R_WINDOW  = 5'h04;
  localparam logic [AW-1:0] R_PER_LO  = 5'h05;
  localparam logic [AW-1:0] R_SPAN_LO = 5'h07;
  localparam logic [AW-1:0] R_OFS_LO  = 5'h09;
  localparam logic [AW-1:0] R_RISE_LO = 5'h0b;
  localparam logic [AW-1:0] R_FALL_LO = 5'h0d;
  localparam logic [AW-1:0] R_STEP_LO = 5'h0f;
  localparam logic [AW-1:0] R_PATCFG  = 5'h11;
  localparam logic [AW-1:0] R_TAPS    = 5'h12;
  localparam logic [AW-1:0] R_BAUD    = 5'h13;
  localparam logic [AW-1:0] R_LENGTH  = 5'h14;
  localparam logic [AW-1:0] R_PREAMB  = 5'h15;
  localparam logic [AW-1:0] R_LOOPS   = 5'h16;
  // control bits
  localparam int unsigned C_RUN    = 0;
  localparam int unsigned C_TRIG   = 1;
  localparam int unsigned C_DOUBLE = 2;
  localparam int unsigned C_CLRERR = 3;
  localparam int unsigned C_PATTERN = 4;
  // pattern config fields
  localparam int unsigned P_TYPE_LSB = 0;
  localparam int unsigned P_NLEV_LSB = 4;
  // error codes, lowest code has priority
  typedef enum logic [2:0] {
    ERR_NONE  = 3'h0,
    ERR_AMPL  = 3'h1,
    ERR_TIMING = 3'h2,
    ERR_EDGE  = 3'h3,
    ERR_DELAY = 3'h4,
    ERR_GEN   = 3'h5
  } pcpg_err_t;
  // time base
  localparam longint TU_PS      = 100;
  localparam longint PS_PER_S   = 64'd1_000_000_000_000;
  localparam longint SPAN_MAX_PS = 64'd1_600_000_000_000;
  localparam longint PER_MIN_PS = 800;
  localparam longint EDGE_MIN_PS = 1_000;
  localparam longint EDGE_MAX_PS = 64'd100_000_000_000;
  localparam longint OFS_MIN_PS = 200;
  localparam longint OFS_GAP_PS = 200;
  localparam longint RES_MIN_PS = 200;
  localparam longint SCLK_MAX_HZ = 64'd5_000_000_000;
  localparam longint MEM_MAX_PTS = 32_000_000;
  localparam int unsigned TW = 44;
  localparam logic [TW-1:0] SPAN_MAX_U = TW'(SPAN_MAX_PS / TU_PS);
  localparam logic [TW-1:0] PER_MIN_U  = TW'(PER_MIN_PS / TU_PS);
  localparam logic [TW-1:0] EDGE_MIN_U = TW'(EDGE_MIN_PS / TU_PS);
  localparam logic [TW-1:0] EDGE_MAX_U = TW'(EDGE_MAX_PS / TU_PS);
  localparam logic [TW-1:0] OFS_MIN_U  = TW'(OFS_MIN_PS / TU_PS);
  localparam logic [TW-1:0] OFS_MAX_U  = TW'((SPAN_MAX_PS - OFS_GAP_PS) / TU_PS);
  localparam logic [TW-1:0] RES_MIN_U  = TW'(RES_MIN_PS / TU_PS);
  localparam logic [TW-1:0] SCLK_MIN_U = TW'(PS_PER_S / SCLK_MAX_HZ / TU_PS);
  localparam logic [TW-1:0] MEM_MAX_U  = TW'(MEM_MAX_PTS);
  localparam logic [31:0]   CLK_HZ     = 32'd50_000_000;
  localparam logic [30:0]   LFSR_SEED  = 31'h7fffffff;
  // reset values, index order
  localparam logic [NREG-1:0][31:0] REG_RST = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam logic [31:0] RST_LEVELS = 32'hfe0c_01f4;
  localparam logic [31:0] RST_AMPLIM = 32'h0fa0_0032;
  localparam logic [31:0] RST_WINDOW = 32'hf060_0fa0;
  localparam logic [31:0] RST_PATCFG = 32'h0000_0020;
  localparam logic [31:0] RST_BAUD   = 32'h0098_9680;
  localparam logic [31:0] RST_LENGTH = 32'h0000_007f;
  localparam logic [31:0] RST_PREAMB = 32'h0000_0010;
  localparam logic [31:0] RST_LOOPS  = 32'h0000_0001;
endpackage
`default_nettype wire

// [pcpg_assertions.sv]
/* pcpg_assertions: port checks of pcpg_top.
   assumes one clock domain, attached by the bind below. */
`timescale 1ns/10ps
`default_nettype none
module pcpg_assertions
  import pcpg_pkg::*;
(
  input wire logic                clk_i,
  input wire logic                srst_i,
  input wire logic                ce_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic                wb_ack_o,
  input wire logic                trig_i,
  input wire logic signed [15:0]  sample_o,
  input wire logic                pattern_active_o,
  input wire logic                err_sticky_o,
  input wire pcpg_pkg::pcpg_err_t err_code_o
);
  logic trig_seen_reg;
  logic act_q_reg;
  // trigger memory ends with each pattern run
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trig_seen_reg <= 1'b0;
      act_q_reg     <= 1'b0;
    end else begin
      act_q_reg <= pattern_active_o;
      if (trig_i) begin
        trig_seen_reg <= 1'b1;
      end else if (act_q_reg && !pattern_active_o) begin
        trig_seen_reg <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_ack_pulse;
    wb_ack_o && ce_i |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held past one cycle");
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("request not answered next cycle");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_sticky_set;
    err_code_o != ERR_NONE |-> ##[0:1] err_sticky_o;
  endproperty
  a_sticky_set: assert property (p_sticky_set)
    else $error("conflict did not set sticky flag");
  property p_sticky_clr;
    $fell(err_sticky_o) |-> err_code_o == ERR_NONE &&
      ((wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o));
  endproperty
  a_sticky_clr: assert property (p_sticky_clr)
    else $error("sticky flag dropped without clear");
  property p_code_cause;
    $changed(err_code_o) |-> $past(wb_we_i && wb_ack_o) ||
      $past(wb_we_i && wb_ack_o, 2) || $past(srst_i) || $past(srst_i, 2);
  endproperty
  a_code_cause: assert property (p_code_cause)
    else $error("error code moved without a write");
  property p_code_range;
    err_code_o <= ERR_GEN;
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("error code out of range");
  property p_freeze;
    !ce_i |=> $stable(sample_o) && $stable(wb_ack_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");
  property p_active_trig;
    pattern_active_o |-> trig_seen_reg;
  endproperty
  a_active_trig: assert property (p_active_trig)
    else $error("pattern left preamble without trigger");
  c_play: cover property ($rose(pattern_active_o));
  c_clear: cover property ($fell(err_sticky_o));
  c_gen: cover property (err_code_o == ERR_GEN);
endmodule
bind pcpg_top pcpg_assertions i_chk (.clk_i(clk_i), .srst_i(srst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .trig_i(trig_i), .sample_o(sample_o),
  .pattern_active_o(pattern_active_o), .err_sticky_o(err_sticky_o),
  .err_code_o(err_code_o));
`default_nettype wire

// [pcpg_far.sv]
/* pcpg_far: trigger source and sample sink of pcpg_top.
   assumes levels top 500 and bottom -500 while counting. */
`timescale 1ns/10ps
`default_nettype none
module pcpg_far (
  input  wire logic              clk_i,
  input  wire logic              clr_i,
  input  wire logic              fire_i,
  input  wire logic [2:0]        nlev_i,
  input  wire logic signed [15:0] sample_i,
  input  wire logic              stb_i,
  input  wire logic              active_i,
  output logic                   trig_o,
  output int                     n_samp_o,
  output int                     n_top_o,
  output int                     n_bad_o,
  output int                     n_cyc_o
);
  logic act_d;
  int   d;
  logic ok;
  initial trig_o = 1'b0;
  always @(posedge clk_i) begin
    trig_o <= fire_i;
    act_d <= active_i;
    if (clr_i) begin
      {n_samp_o, n_top_o, n_bad_o, n_cyc_o} <= '0;
    end else if (act_d) begin
      n_cyc_o <= n_cyc_o + 1;
      if (stb_i) begin
        n_samp_o <= n_samp_o + 1;
        if (sample_i === 16'sh01f4) n_top_o <= n_top_o + 1;
        ok = 1'b0;
        // level must sit on an even step between bottom and top
        for (int j = 0; j < int'(nlev_i); j++) begin
          d = (int'(sample_i) + 500) * (int'(nlev_i) - 1) - 1000 * j;
          if (d >= -3 && d <= 3) ok = 1'b1;
        end
        if (ok !== 1'b1) n_bad_o <= n_bad_o + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [test_pulse_check_prbs_pattern_gen.sv]
/* test_pulse_check_prbs_pattern_gen: self-checking bench of pcpg_top.
   assumes pcpg_far as trigger source and sample sink. */
`timescale 1ns/10ps
`default_nettype none
module test_pulse_check_prbs_pattern_gen;
  import pcpg_pkg::*;
  logic        clk_i = 0, srst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, rdat, wb_dat_o;
  logic [3:0]  sel = 4'hf;
  logic        wb_ack_o, trig_i, sample_stb_o, pattern_active_o, err_sticky_o;
  logic signed [15:0] sample_o;
  pcpg_err_t   err_code_o;
  logic        clr = 1, fire = 0;
  logic [2:0]  nlev = 2;
  int          fail_count = 0, checked = 0, n_samp, n_top, n_bad, n_cyc;
  pcpg_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_i(trig_i), .sample_o(sample_o),
    .sample_stb_o(sample_stb_o), .pattern_active_o(pattern_active_o),
    .err_sticky_o(err_sticky_o), .err_code_o(err_code_o));
  pcpg_far i_far (.clk_i(clk_i), .clr_i(clr), .fire_i(fire), .nlev_i(nlev),
    .sample_i(sample_o), .stb_i(sample_stb_o), .active_i(pattern_active_o),
    .trig_o(trig_i), .n_samp_o(n_samp), .n_top_o(n_top), .n_bad_o(n_bad),
    .n_cyc_o(n_cyc));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {25'h0, idx, 2'b00};
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
    rdat = wb_dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic wait_act(input logic lvl, input int lim, output logic hit);
    hit = 0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk_i);
      hit = (pattern_active_o === lvl);
    end
  endtask
  task automatic run(input logic [31:0] ctrl, input int lim, output logic hit);
    clr <= 1;
    wb(1, R_CTRL, ctrl);
    clr <= 0;
    wait_act(1, 100, hit);
    check(hit, 0);
    fire <= 1;
    repeat (4) @(posedge clk_i);
    fire <= 0;
    wait_act(1, 200, hit);
    check(hit, 1);
    wait_act(0, lim, hit);
    // far counters take the last sample one edge later
    @(posedge clk_i);
  endtask
  task automatic t_regs();
    logic [4:0]  ri [9] = '{R_CTRL, R_LEVELS, R_AMPLIM, R_WINDOW, R_PATCFG,
      R_BAUD, R_LENGTH, R_PREAMB, R_LOOPS};
    logic [31:0] rv [9] = '{32'h0, RST_LEVELS, RST_AMPLIM, RST_WINDOW,
      RST_PATCFG, RST_BAUD, RST_LENGTH, RST_PREAMB, RST_LOOPS};
    for (int i = 0; i < 9; i++) begin
      wb(0, ri[i], 0);
      check(rdat, rv[i]);
    end
    check(err_code_o, ERR_TIMING);
    wb(1, R_STATUS, 0);
    wb(0, R_STATUS, 0);
    check(rdat, 32'h15);
    wb(1, 5'h17, 32'hffff_ffff);
    wb(0, 5'h17, 0);
    check(rdat, 0);
    sel <= 4'h1;
    wb(1, R_LOOPS, 32'hffff_ff01);
    sel <= 4'hf;
    wb(0, R_LOOPS, 0);
    check(rdat, 1);
    ce_i <= 0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1;
  endtask
  task automatic t_err();
    logic [39:0] et [35] = '{
      {5'h05,32'h2710,3'h3}, {5'h07,32'h3e8,3'h3}, {5'h0b,32'h64,3'h3},
      {5'h0d,32'h64,3'h4}, {5'h09,32'h64,3'h5}, {5'h0f,32'ha,3'h0},
      {5'h02,32'h01f4_fe0c,3'h1}, {5'h02,32'h05dc_0bb8,3'h1},
      {5'h02,32'hfe0c_01f4,3'h0}, {5'h05,32'h7,3'h2}, {5'h05,32'h8,3'h0},
      {5'h06,32'h4,3'h2}, {5'h06,32'h0,3'h0}, {5'h05,32'h2710,3'h0},
      {5'h0b,32'h3e9,3'h2}, {5'h0b,32'h3e8,3'h0}, {5'h0d,32'h9,3'h3},
      {5'h0d,32'h3b9a_ca01,3'h3}, {5'h0d,32'h3b9a_ca00,3'h0},
      {5'h0d,32'h64,3'h0}, {5'h08,32'h4,3'h3}, {5'h08,32'h0,3'h0},
      {5'h09,32'h1,3'h4}, {5'h09,32'h2,3'h0}, {5'h0a,32'h3,3'h0},
      {5'h09,32'hb9ac_9b82,3'h0}, {5'h00,32'h4,3'h4}, {5'h00,32'h0,3'h0},
      {5'h09,32'hb9ac_9c18,3'h4}, {5'h0a,32'h0,3'h0}, {5'h09,32'h64,3'h0},
      {5'h0f,32'h1,3'h5}, {5'h0f,32'h2,3'h0}, {5'h05,32'h03d0_9001,3'h5},
      {5'h05,32'h2710,3'h0}};
    for (int i = 0; i < 35; i++) begin
      wb(1, et[i][39:35], et[i][34:3]);
      repeat (2) @(posedge clk_i);
      check(err_code_o, et[i][2:0]);
    end
    check(err_sticky_o, 1);
    wb(1, R_CTRL, 32'h8);
    repeat (2) @(posedge clk_i);
    check(err_sticky_o, 0);
    wb(1, R_PER_LO, 32'h7);
    wb(1, R_CTRL, 32'h8);
    repeat (2) @(posedge clk_i);
    check(err_sticky_o, 1);
    wb(1, R_PER_LO, 32'h2710);
  endtask
  task automatic t_prbs();
    int   nb [6] = '{7, 9, 11, 15, 23, 31};
    int   len;
    logic hit;
    for (int t = 0; t < 6; t++) begin
      len = (t < 3) ? (1 << nb[t]) - 1 : 64;
      wb(1, R_LENGTH, len);
      wb(1, R_PATCFG, 32'h20 | t);
      run(32'h13, 6 * len + 200, hit);
      check(hit, 1);
      check(n_samp, len);
      if (t < 3) check(n_top, (len + 1) / 2);
      check(n_bad, 0);
      wb(1, R_CTRL, 0);
    end
    wb(1, R_LENGTH, 127);
    wb(1, R_PATCFG, 32'h20);
    wb(1, R_LOOPS, 2);
    run(32'h13, 1500, hit);
    check(hit, 1);
    check(n_samp, 254);
    check(n_top, 128);
    wb(1, R_CTRL, 0);
    run(32'h11, 1500, hit);
    check(hit, 0);
    check(n_samp > 254, 1);
    wb(1, R_CTRL, 0);
    wb(1, R_LOOPS, 1);
    for (int n = 3; n < 6; n++) begin
      nlev <= 3'(n);
      wb(1, R_PATCFG, n << 4);
      run(32'h13, 800, hit);
      check(hit, 1);
      check(n_bad, 0);
      check(n_top > 0, 1);
      wb(1, R_CTRL, 0);
    end
    nlev <= 2;
    wb(1, R_PATCFG, 32'h20);
    wb(1, R_BAUD, 32'h017d_7840);
    run(32'h13, 800, hit);
    check(hit, 1);
    check(n_samp, 127);
    check(n_cyc >= 250 && n_cyc <= 258, 1);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 0;
    t_regs();
    t_err();
    t_prbs();
    print_verdict();
  end
endmodule
`default_nettype wire
